/* hdl/rfscfg_map.svh */
/*
  Constants of the system configuration command block: default settings,
  error status layout and fixed-point formats.
  Assumes power values are signed tenths of a dB or dBm.
*/
`ifndef RFSCFG_MAP_SVH
`define RFSCFG_MAP_SVH

// ===========================================================
// Formats
`define RFSCFG_PWR_W      16
`define RFSCFG_ERR_W      32
`define RFSCFG_CHAN_W     8

// ===========================================================
// Defaults (tenths of dB / dBm; serial rate in baud)
`define RFSCFG_OFS_RST    16'h0000
`define RFSCFG_MAX_RST    16'h01D7
`define RFSCFG_MIN_RST    16'h010E
`define RFSCFG_SP_RST     16'h010E
`define RFSCFG_BAUD_RST   32'h0001C200

// ===========================================================
// Error status
`define RFSCFG_ERR_RSTDET 32'h00000020
`define RFSCFG_ERR_CLR    32'h00000000

`endif

/* hdl/rfscfg_pkg.sv */
/*
  Types of the system configuration command block.
  Assumes an upstream parser that turns ASCII lines into opcodes.
*/
package rfscfg_pkg;

  // ===========================================================
  // Command opcodes
  typedef enum logic [3:0] {
    RFSCFG_OP_SET_OFS  = 4'h0,
    RFSCFG_OP_GET_OFS  = 4'h1,
    RFSCFG_OP_RD_W     = 4'h2,
    RFSCFG_OP_RD_DBM   = 4'h3,
    RFSCFG_OP_SP_W     = 4'h4,
    RFSCFG_OP_SP_DBM   = 4'h5,
    RFSCFG_OP_GET_MAX  = 4'h6,
    RFSCFG_OP_SET_MAX  = 4'h7,
    RFSCFG_OP_GET_MIN  = 4'h8,
    RFSCFG_OP_SET_MIN  = 4'h9,
    RFSCFG_OP_RST      = 4'hA,
    RFSCFG_OP_BAUD     = 4'hB,
    RFSCFG_OP_CLR_ERR  = 4'hC,
    RFSCFG_OP_ERR_Q    = 4'hD
  } rfscfg_op_type;

  // ===========================================================
  // Reply kinds
  typedef enum logic [1:0] {
    RFSCFG_RSP_OK  = 2'h0,
    RFSCFG_RSP_ERR = 2'h1,
    RFSCFG_RSP_VAL = 2'h2
  } rfscfg_rsp_type;

  // ===========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    RFSCFG_ST_IDLE = 3'h1,
    RFSCFG_ST_RESP = 3'h2,
    RFSCFG_ST_RST  = 3'h4
  } rfscfg_state_type;

endpackage

/* hdl/rfscfg_top.sv */
/*
  System configuration command interpreter of an RF source board:
  power offset, setpoint caps, board reset, error status, serial rate.
  Assumes parsed commands and measurements arrive on sys_clk_i.
*/
`timescale 1ns/10ps
`include "rfscfg_map.svh"

module rfscfg_top
(
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          srst_i,
  // Command
  input  wire logic                          cmd_valid_i,
  output logic                               cmd_ready_o,
  input  wire rfscfg_pkg::rfscfg_op_type     cmd_op_i,
  input  wire logic [`RFSCFG_CHAN_W-1:0]     cmd_chan_i,
  input  wire logic [31:0]                   cmd_arg_i,
  input  wire logic [`RFSCFG_CHAN_W-1:0]     own_chan_i,
  // Measurements and faults
  input  wire logic [`RFSCFG_PWR_W-1:0]      fwd_dbm_i,
  input  wire logic [`RFSCFG_PWR_W-1:0]      refl_dbm_i,
  input  wire logic [`RFSCFG_ERR_W-1:0]      err_event_i,
  // Response
  output logic                               rsp_valid_o,
  input  wire logic                          rsp_ready_i,
  output rfscfg_pkg::rfscfg_op_type          rsp_op_o,
  output logic [`RFSCFG_CHAN_W-1:0]          rsp_chan_o,
  output rfscfg_pkg::rfscfg_rsp_type         rsp_kind_o,
  output logic [31:0]                        rsp_val_o,
  output logic [`RFSCFG_PWR_W-1:0]           rsp_aux_o,
  // Settings, error status and soft reset
  output logic [`RFSCFG_PWR_W-1:0]           offset_o,
  output logic [`RFSCFG_PWR_W-1:0]           max_cap_o,
  output logic [`RFSCFG_PWR_W-1:0]           min_lim_o,
  output logic [`RFSCFG_PWR_W-1:0]           setpoint_o,
  output logic [`RFSCFG_PWR_W-1:0]           setpoint_gen_o,
  output logic [31:0]                        uart_baud_o,
  output logic [`RFSCFG_ERR_W-1:0]           err_status_o,
  output logic                               soft_rst_o
);
  import rfscfg_pkg::*;

  // ===========================================================
  // State
  rfscfg_state_type                 state_ff;
  rfscfg_state_type                 nxt_state;
  logic                             cmd_ready_ff;
  logic                             rsp_valid_ff;
  rfscfg_op_type                    rsp_op_ff;
  logic [`RFSCFG_CHAN_W-1:0]        rsp_chan_ff;
  rfscfg_rsp_type                   rsp_kind_ff;
  logic [31:0]                      rsp_val_ff;
  logic [`RFSCFG_PWR_W-1:0]         rsp_aux_ff;
  logic [`RFSCFG_PWR_W-1:0]         ofs_ff;
  logic [`RFSCFG_PWR_W-1:0]         max_ff;
  logic [`RFSCFG_PWR_W-1:0]         min_ff;
  logic [`RFSCFG_PWR_W-1:0]         sp_ff;
  logic [`RFSCFG_PWR_W-1:0]         sp_gen_ff;
  logic [31:0]                      baud_ff;
  logic [`RFSCFG_ERR_W-1:0]         err_ff;

  // ===========================================================
  // Decode
  wire                              take;
  wire                              chan_hit;
  wire                              do_cmd;
  wire                              no_reply;
  wire                              need_reply;
  wire                              rsp_done;
  wire                              any_rst;
  wire                              is_sp;
  wire                              is_get;
  wire                              known_op;
  wire                              sp_ok;
  wire signed [16:0]                arg_s;
  wire signed [16:0]                sp_lo;
  wire signed [16:0]                sp_hi;
  wire [`RFSCFG_PWR_W-1:0]          arg16;
  wire [`RFSCFG_PWR_W-1:0]          fwd_adj;
  wire [`RFSCFG_PWR_W-1:0]          refl_adj;
  wire [31:0]                       get_val;
  wire [`RFSCFG_PWR_W-1:0]          get_aux;
  wire rfscfg_rsp_type              kind;
  wire [`RFSCFG_PWR_W-1:0]          nxt_ofs;
  wire [`RFSCFG_PWR_W-1:0]          nxt_max;
  wire [`RFSCFG_PWR_W-1:0]          nxt_min;
  wire [`RFSCFG_PWR_W-1:0]          nxt_sp;
  wire [`RFSCFG_PWR_W-1:0]          nxt_sp_gen;
  wire [31:0]                       nxt_baud;
  wire [`RFSCFG_ERR_W-1:0]          nxt_err;
  wire [`RFSCFG_ERR_W-1:0]          err_kept;

  assign take       = cmd_valid_i & cmd_ready_ff;
  assign chan_hit   = (cmd_chan_i == own_chan_i);
  assign do_cmd     = take & chan_hit;
  assign no_reply   = (cmd_op_i == RFSCFG_OP_BAUD);
  assign need_reply = do_cmd & ~no_reply;
  assign rsp_done   = rsp_valid_ff & rsp_ready_i;
  assign any_rst    = srst_i | (state_ff == RFSCFG_ST_RST);

  assign is_sp    = (cmd_op_i == RFSCFG_OP_SP_W) | (cmd_op_i == RFSCFG_OP_SP_DBM);
  assign is_get   = (cmd_op_i == RFSCFG_OP_GET_OFS) | (cmd_op_i == RFSCFG_OP_RD_W)
                  | (cmd_op_i == RFSCFG_OP_RD_DBM) | (cmd_op_i == RFSCFG_OP_GET_MAX)
                  | (cmd_op_i == RFSCFG_OP_GET_MIN) | (cmd_op_i == RFSCFG_OP_ERR_Q);
  assign known_op = (cmd_op_i <= RFSCFG_OP_ERR_Q);

  // Setpoint window at the offset plane
  assign arg16 = cmd_arg_i[15:0];
  assign arg_s = {arg16[15], arg16};
  assign sp_lo = $signed({min_ff[15], min_ff}) - $signed({ofs_ff[15], ofs_ff});
  assign sp_hi = $signed({max_ff[15], max_ff}) - $signed({ofs_ff[15], ofs_ff});
  assign sp_ok = (arg_s >= sp_lo) & (arg_s <= sp_hi);

  // Forward reading referred to the offset plane; reflected reading has the offset added
  assign fwd_adj  = fwd_dbm_i - ofs_ff;
  assign refl_adj = refl_dbm_i + ofs_ff;

  // Reply value selection
  assign get_val =
    (cmd_op_i == RFSCFG_OP_GET_OFS) ? {{16{ofs_ff[15]}}, ofs_ff} :
    ((cmd_op_i == RFSCFG_OP_RD_W) | (cmd_op_i == RFSCFG_OP_RD_DBM)) ?
      {{16{fwd_adj[15]}}, fwd_adj} :
    (cmd_op_i == RFSCFG_OP_GET_MAX) ? {{16{max_ff[15]}}, max_ff} :
    (cmd_op_i == RFSCFG_OP_GET_MIN) ? {{16{min_ff[15]}}, min_ff} :
    (cmd_op_i == RFSCFG_OP_ERR_Q)   ? err_ff : 32'h00000000;
  assign get_aux = ((cmd_op_i == RFSCFG_OP_RD_W) | (cmd_op_i == RFSCFG_OP_RD_DBM)) ?
                   refl_adj : 16'h0000;
  assign kind = ~known_op        ? RFSCFG_RSP_ERR :
                is_get           ? RFSCFG_RSP_VAL :
                (is_sp & ~sp_ok) ? RFSCFG_RSP_ERR : RFSCFG_RSP_OK;

  // Setting updates; any reset restores the defaults
  assign nxt_ofs = any_rst ? `RFSCFG_OFS_RST :
                   (do_cmd & (cmd_op_i == RFSCFG_OP_SET_OFS)) ? arg16 : ofs_ff;
  assign nxt_max = any_rst ? `RFSCFG_MAX_RST :
                   (do_cmd & (cmd_op_i == RFSCFG_OP_SET_MAX)) ? arg16 : max_ff;
  assign nxt_min = any_rst ? `RFSCFG_MIN_RST :
                   (do_cmd & (cmd_op_i == RFSCFG_OP_SET_MIN)) ? arg16 : min_ff;
  assign nxt_sp  = any_rst ? `RFSCFG_SP_RST :
                   (do_cmd & is_sp & sp_ok) ? arg16 : sp_ff;
  assign nxt_sp_gen = nxt_sp + nxt_ofs;
  assign nxt_baud = any_rst ? `RFSCFG_BAUD_RST :
                    (do_cmd & no_reply) ? cmd_arg_i : baud_ff;

  // Error flags: a new event wins over the clear
  assign err_kept = (do_cmd & (cmd_op_i == RFSCFG_OP_CLR_ERR)) ?
                    `RFSCFG_ERR_CLR : err_ff;
  assign nxt_err  = err_kept | err_event_i | (any_rst ? `RFSCFG_ERR_RSTDET : `RFSCFG_ERR_CLR);

  // ===========================================================
  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      RFSCFG_ST_IDLE:
      begin
        if (need_reply)
        begin
          nxt_state = RFSCFG_ST_RESP;
        end
      end
      RFSCFG_ST_RESP:
      begin
        if (rsp_done)
        begin
          nxt_state = (rsp_op_ff == RFSCFG_OP_RST) ? RFSCFG_ST_RST : RFSCFG_ST_IDLE;
        end
      end
      RFSCFG_ST_RST:
      begin
        nxt_state = RFSCFG_ST_IDLE;
      end
      default:
      begin
        nxt_state = RFSCFG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state_ff     <= RFSCFG_ST_IDLE;
      cmd_ready_ff <= 1'b1;
    end
    else
    begin
      state_ff     <= nxt_state;
      cmd_ready_ff <= (nxt_state == RFSCFG_ST_IDLE);
    end
  end

  // ===========================================================
  // Response holding register
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_op_ff    <= RFSCFG_OP_SET_OFS;
      rsp_chan_ff  <= 8'h00;
      rsp_kind_ff  <= RFSCFG_RSP_OK;
      rsp_val_ff   <= 32'h00000000;
      rsp_aux_ff   <= 16'h0000;
    end
    else if (need_reply)
    begin
      rsp_valid_ff <= 1'b1;
      rsp_op_ff    <= cmd_op_i;
      rsp_chan_ff  <= own_chan_i;
      rsp_kind_ff  <= kind;
      rsp_val_ff   <= get_val;
      rsp_aux_ff   <= get_aux;
    end
    else if (rsp_done)
    begin
      rsp_valid_ff <= 1'b0;
    end
  end

  // ===========================================================
  // Settings and error status
  always_ff @(posedge sys_clk_i)
  begin
    ofs_ff    <= nxt_ofs;
    max_ff    <= nxt_max;
    min_ff    <= nxt_min;
    sp_ff     <= nxt_sp;
    sp_gen_ff <= nxt_sp_gen;
    baud_ff   <= nxt_baud;
    err_ff    <= nxt_err;
  end

  // ===========================================================
  // Outputs
  assign cmd_ready_o    = cmd_ready_ff;
  assign rsp_valid_o    = rsp_valid_ff;
  assign rsp_op_o       = rsp_op_ff;
  assign rsp_chan_o     = rsp_chan_ff;
  assign rsp_kind_o     = rsp_kind_ff;
  assign rsp_val_o      = rsp_val_ff;
  assign rsp_aux_o      = rsp_aux_ff;
  assign offset_o       = ofs_ff;
  assign max_cap_o      = max_ff;
  assign min_lim_o      = min_ff;
  assign setpoint_o     = sp_ff;
  assign setpoint_gen_o = sp_gen_ff;
  assign uart_baud_o    = baud_ff;
  assign err_status_o   = err_ff;
  assign soft_rst_o     = state_ff[2];

endmodule

/* verif/rfscfg_assertions.sv */
/*
  Concurrent checks on the ports of the configuration command block.
  Assumes binding to rfscfg_top, one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "rfscfg_map.svh"
module rfscfg_assertions
(
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          srst_i,
  // Command and response
  input  wire logic                          cmd_valid_i,
  input  wire logic                          cmd_ready_o,
  input  wire rfscfg_pkg::rfscfg_op_type     cmd_op_i,
  input  wire logic [`RFSCFG_CHAN_W-1:0]     cmd_chan_i,
  input  wire logic [31:0]                   cmd_arg_i,
  input  wire logic [`RFSCFG_CHAN_W-1:0]     own_chan_i,
  input  wire logic                          rsp_valid_o,
  input  wire rfscfg_pkg::rfscfg_rsp_type    rsp_kind_o,
  // Settings, error status and soft reset
  input  wire logic [`RFSCFG_PWR_W-1:0]      offset_o,
  input  wire logic [`RFSCFG_PWR_W-1:0]      max_cap_o,
  input  wire logic [`RFSCFG_PWR_W-1:0]      min_lim_o,
  input  wire logic [`RFSCFG_PWR_W-1:0]      setpoint_o,
  input  wire logic [31:0]                   uart_baud_o,
  input  wire logic [`RFSCFG_ERR_W-1:0]      err_status_o,
  input  wire logic                          soft_rst_o
);
  import rfscfg_pkg::*;
  // ===========================================================
  // Decode
  wire               tk  = cmd_valid_i && cmd_ready_o && (cmd_chan_i == own_chan_i);
  wire               spc = (cmd_op_i == RFSCFG_OP_SP_W) || (cmd_op_i == RFSCFG_OP_SP_DBM);
  wire signed [16:0] hi  = $signed(max_cap_o) - $signed(offset_o);
  wire signed [16:0] lo  = $signed(min_lim_o) - $signed(offset_o);
  wire               oor = ($signed(cmd_arg_i[15:0]) > hi) || ($signed(cmd_arg_i[15:0]) < lo);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ===========================================================
  // Properties
  sequence s_rst_take; tk && cmd_op_i == RFSCFG_OP_RST; endsequence
  sequence s_rst_ok; rsp_valid_o && rsp_kind_o == RFSCFG_RSP_OK && !soft_rst_o; endsequence
  property p_ofs_set; tk && cmd_op_i == RFSCFG_OP_SET_OFS |=>
    offset_o == $past(cmd_arg_i[15:0]) && rsp_valid_o && rsp_kind_o == RFSCFG_RSP_OK; endproperty
  property p_max_set; tk && cmd_op_i == RFSCFG_OP_SET_MAX |=>
    max_cap_o == $past(cmd_arg_i[15:0]) && rsp_kind_o == RFSCFG_RSP_OK; endproperty
  property p_min_set; tk && cmd_op_i == RFSCFG_OP_SET_MIN |=>
    min_lim_o == $past(cmd_arg_i[15:0]) && rsp_kind_o == RFSCFG_RSP_OK; endproperty
  property p_sp_bad; tk && spc && oor |=> $stable(setpoint_o) && rsp_kind_o == RFSCFG_RSP_ERR;
  endproperty
  property p_sp_ok; tk && spc && !oor |=> setpoint_o == $past(cmd_arg_i[15:0]); endproperty
  property p_baud; tk && cmd_op_i == RFSCFG_OP_BAUD |=>
    uart_baud_o == $past(cmd_arg_i) && !rsp_valid_o; endproperty
  property p_chan; cmd_valid_i && cmd_ready_o && cmd_chan_i != own_chan_i |=>
    !rsp_valid_o && cmd_ready_o; endproperty
  property p_rst_ord; s_rst_take |=> s_rst_ok ##[1:8] soft_rst_o; endproperty
  property p_rst_dflt; $rose(soft_rst_o) |=> max_cap_o == `RFSCFG_MAX_RST &&
    min_lim_o == `RFSCFG_MIN_RST && offset_o == `RFSCFG_OFS_RST &&
    uart_baud_o == `RFSCFG_BAUD_RST && err_status_o[5]; endproperty
  property p_err_hold; !(tk && cmd_op_i == RFSCFG_OP_CLR_ERR) |=>
    (err_status_o & $past(err_status_o)) == $past(err_status_o); endproperty
  // ===========================================================
  // Assertions
  a_ofs_set: assert property (p_ofs_set) else $error("offset set wrong");
  a_max_set: assert property (p_max_set) else $error("max set wrong");
  a_min_set: assert property (p_min_set) else $error("min set wrong");
  a_sp_bad: assert property (p_sp_bad) else $error("bad setpoint taken");
  a_sp_ok: assert property (p_sp_ok) else $error("good setpoint lost");
  a_baud: assert property (p_baud) else $error("rate wrong or replied");
  a_chan: assert property (p_chan) else $error("foreign channel answered");
  a_rst_ord: assert property (p_rst_ord) else $error("reset order wrong");
  a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults wrong");
  a_err_hold: assert property (p_err_hold) else $error("error bit lost");
endmodule

/* verif/rfscfg_host.sv */
/*
  Host model: sends one command, waits for it to be taken, accepts any reply.
  Assumes the bench clock; drives on falling edges.
*/
`timescale 1ns/10ps
module rfscfg_host
(
  // Clock
  input  wire logic        clk_i,
  // Command
  output logic             cmd_valid_o,
  input  wire logic        cmd_ready_i,
  output logic [3:0]       cmd_op_o,
  output logic [7:0]       cmd_chan_o,
  output logic [31:0]      cmd_arg_o,
  // Response
  input  wire logic        rsp_valid_i,
  output logic             rsp_ready_o
);
  logic [31:0] line_baud = 32'h0001C200;
  initial {cmd_valid_o, rsp_ready_o, cmd_op_o, cmd_chan_o, cmd_arg_o} = '0;
  task automatic send(input logic [3:0] op, input logic [7:0] ch, input logic [31:0] arg,
                      output logic got);
    int n;
    n = 0;
    got = 0;
    @(negedge clk_i);
    {cmd_valid_o, cmd_op_o, cmd_chan_o, cmd_arg_o} = {1'b1, op, ch, arg};
    while (!cmd_ready_i && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    cmd_valid_o = 0;
    cmd_arg_o = ~arg;
    if (op == 4'hB) line_baud = arg;
    n = 0;
    while (!rsp_valid_i && n < 3)
    begin
      @(negedge clk_i);
      n++;
    end
    if (rsp_valid_i)
    begin
      got = 1;
      repeat ($urandom_range(0, 2)) @(negedge clk_i);
      rsp_ready_o = 1;
      @(negedge clk_i);
      rsp_ready_o = 0;
    end
  endtask
endmodule

/* verif/test_rfscfg_top.sv */
/*
  Self-checking bench of rfscfg_top against a reference model.
  Assumes rfscfg_host as command source, 125 MHz clock.
*/
`timescale 1ns/10ps
`include "rfscfg_map.svh"
module test_rfscfg_top;
  import rfscfg_pkg::*;
  logic        sys_clk_i = 0, srst_i = 1, cv, cr, rv, rr, srst_o;
  logic [3:0]  op;
  logic [7:0]  ch, own;
  logic [31:0] arg, baud, err, ev, v, mb, me;
  logic [15:0] fwd, refl, ofs_o, max_o, min_o, sp_o, gen_o, aux, ax;
  logic [1:0]  k;
  logic [3:0]  ro, oc;
  logic [7:0]  rc, cc;
  int          ofs, mx, mn, sp, mismatches, num_checks, cyc;
  rfscfg_top i_rfscfg_top (.sys_clk_i, .srst_i, .cmd_valid_i(cv), .cmd_ready_o(cr),
    .cmd_op_i(rfscfg_op_type'(op)), .cmd_chan_i(ch), .cmd_arg_i(arg), .own_chan_i(own),
    .fwd_dbm_i(fwd), .refl_dbm_i(refl), .err_event_i(ev), .rsp_valid_o(rv), .rsp_ready_i(rr),
    .rsp_op_o(ro), .rsp_chan_o(rc), .rsp_kind_o(k), .rsp_val_o(v), .rsp_aux_o(ax),
    .offset_o(ofs_o), .max_cap_o(max_o), .min_lim_o(min_o), .setpoint_o(sp_o),
    .setpoint_gen_o(gen_o), .uart_baud_o(baud), .err_status_o(err), .soft_rst_o(srst_o));
  rfscfg_host i_rfscfg_host (.clk_i(sys_clk_i), .cmd_valid_o(cv), .cmd_ready_i(cr),
    .cmd_op_o(op), .cmd_chan_o(ch), .cmd_arg_o(arg), .rsp_valid_i(rv), .rsp_ready_o(rr));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  logic [1:0]  kc;
  logic [31:0] vc;
  always @(posedge sys_clk_i) if (rv && rr) {kc, vc, aux, oc, cc} <= {k, v, ax, ro, rc};
  // ===========================================================
  // Model and checks
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task dflt;
    {ofs, mx, mn, sp} = {32'h0, 32'h1D7, 32'h10E, 32'h10E};
    mb = 32'h0001C200;
    me |= 32'h20;
  endtask
  function automatic logic [31:0] rarg(input logic [3:0] o);
    int b;
    b = $urandom_range(0, 1) ? mn - ofs : mx - ofs;
    case (o)
      0: return $urandom_range(0, 120);
      4, 5: return b + $urandom_range(0, 2) - 1;
      7, 9: return $urandom_range(150, 500);
      default: return $urandom;
    endcase
  endfunction
  task do_cmd(input logic [3:0] o, input logic [7:0] c, input logic [31:0] x);
    logic got, er;
    int ek, e, ea;
    {er, ek, e, ea} = {(c == own) && o != 4'hB, 96'h0};
    fwd = $urandom_range(0, 600);
    refl = $urandom_range(0, 300);
    if (c == own)
      case (o)
        0: ofs = $signed(x[15:0]);
        1: {ek, e} = {2, ofs};
        2, 3: {ek, e, ea} = {2, fwd - ofs, refl + ofs};
        4, 5: if ($signed(x[15:0]) > mx - ofs || $signed(x[15:0]) < mn - ofs) ek = 1;
          else sp = $signed(x[15:0]);
        6: {ek, e} = {2, mx};
        7: mx = $signed(x[15:0]);
        8: {ek, e} = {2, mn};
        9: mn = $signed(x[15:0]);
        10: dflt();
        11: mb = x;
        12: me = ev;
        13: {ek, e} = {2, me};
        default: ek = 1;
      endcase
    i_rfscfg_host.send(o, c, x, got);
    repeat (2) @(negedge sys_clk_i);
    chk(got, er);
    if (er) chk(kc, ek);
    if (er) chk(vc, e);
    if (er) chk(aux, ea[15:0]);
    if (er) chk(oc, o);
    if (er) chk(cc, own);
    chk(ofs_o, ofs[15:0]);
    chk(max_o, mx[15:0]);
    chk(min_o, mn[15:0]);
    chk(sp_o, sp[15:0]);
    chk(gen_o, 16'(sp + ofs));
    chk(baud, mb);
    chk(err, me);
  endtask
  // ===========================================================
  // Sequence
  initial
  begin
    void'($urandom(32'hBBC9));
    {ev, fwd, refl, me, mismatches, num_checks, cyc} = '0;
    own = $urandom_range(1, 9);
    dflt();
    repeat (4) @(negedge sys_clk_i);
    srst_i = 0;
    for (int i = 0; i < 15; i++) do_cmd(i, own, rarg(i));
    do_cmd(4'h7, own + 8'h1, 32'h0);
    @(negedge sys_clk_i);
    ev = 32'h440;
    me |= ev;
    @(negedge sys_clk_i);
    ev = 0;
    do_cmd(4'hD, own, 32'h0);
    for (int i = 0; i < 90; i++)
    begin
      op = $urandom_range(0, 14);
      do_cmd(op, ($urandom_range(0, 7) == 0) ? own + 8'h1 : own, rarg(op));
    end
    end_sim();
  end
endmodule
bind rfscfg_top rfscfg_assertions u_chk (.sys_clk_i, .srst_i, .cmd_valid_i, .cmd_ready_o,
  .cmd_op_i, .cmd_chan_i, .cmd_arg_i, .own_chan_i, .rsp_valid_o, .rsp_kind_o, .offset_o,
  .max_cap_o, .min_lim_o, .setpoint_o, .uart_baud_o, .err_status_o, .soft_rst_o);
